// ===== pmrs_map.svh
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef PMRS_MAP_SVH
`define PMRS_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 5
`define RST_HOLD_NS 100
`define RST_HOLD_CYC ((`RST_HOLD_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define HOLD_CNT_W 16

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define CTRL_W 9
`define CTRL_RESET 9'h000
`define CTRL_DET_EN 0
`define CTRL_DET_FALL 1
`define CTRL_DET_RISE 2
`define CTRL_LP_REG 3
`define CTRL_UNDER_DRIVE 4
`define CTRL_DEEP 5
`define CTRL_STANDBY 6
`define CTRL_ENTER 7
`define CTRL_BKP_SRAM 8

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define STAT_DET_OUT 0
`define STAT_DET_FLAG 1
`define STAT_STBY_FLAG 2

// ----------------------------------------------------------------------
// Brownout option codes
// ----------------------------------------------------------------------
`define BRN_KEEP 3'h0
`define BRN_OFF 3'h4
`define BRN_DEFAULT_SEL 3'h0

`endif

// ===== pmrs_pkg.sv
// Types shared by the power mode and reset supervisor
package pmrs_pkg;
`include "pmrs_map.svh"

    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_RUN = 5'b00010,
        ST_SLEEP = 5'b00100,
        ST_STOP = 5'b01000,
        ST_STANDBY = 5'b10000
    } pwr_state_e;

    typedef struct packed {
        pwr_state_e state;
        logic [`HOLD_CNT_W-1:0] hold_cnt;
        logic [`CTRL_W-1:0] ctrl;
        logic [2:0] brownout_sel;
        logic opt_done;
        logic det_prev;
        logic wake_prev;
        logic det_flag;
        logic stby_flag;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic sys_reset;
        logic core_halt;
        logic clk_stop;
        logic osc_off;
        logic reg_off;
        logic reg_lp;
        logic reg_ud;
        logic bkp_batt;
        logic bkp_sram;
    } pmrs_s;
endpackage

// ===== pin_sync_bank.sv
// Two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
module pin_sync_bank #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic ce_i, // Clock enable
    input wire logic [W-1:0] d_i, // Raw pins
    output logic [W-1:0] q_o // Synchronised pins
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_s;

    sync_s st;
    sync_s nxt;

    // The first stage feeds only the second stage
    always_comb
    begin
        nxt.meta = d_i;
        nxt.sync = st.meta;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st.meta <= RST_VAL;
            st.sync <= RST_VAL;
        end
        else if (ce_i)
        begin
            st <= nxt;
        end
    end

    assign q_o = st.sync;
endmodule

// ===== power_mode_reset_supervisor.sv
// Power supervision, brownout options, voltage detector and low-power modes
// Operation
// - Reset is held while the supply is under the power-on or brownout level.
// - Option loading keeps the default brownout level, picks one of three, or disables it for good.
// - When enabled, the voltage detector flags falling, rising or both crossings.
// - The reset-disable pin turns off internal supply reset, only where the pin exists.
// - With internal reset off, the detector, battery backup and brownout are all off.
// - Sleep halts only the core, and any peripheral interrupt or event wakes it.
// - Stop halts core-domain clocks and turns off PLL and oscillators, keeping state.
// - In stop the regulator is main or low power, each normal or under-drive.
// - Any external interrupt line source wakes the device from stop.
// - Standby switches off regulator, PLL and oscillators, keeping only backup state.
// - Standby ends on reset pin, watchdog reset, wakeup pin rise or clock event.
// - Standby is refused while the regulator is bypassed.
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pmrs_map.svh"
module power_mode_reset_supervisor #(
    parameter int EXT_LINES = 16,
    parameter bit HAS_RESET_DISABLE_PIN = 1'b1
) (
    input wire logic sys_clk_i, // 200 MHz clock
    input wire logic rst_i, // Synchronous reset, high
    input wire logic ce_i, // Clock enable, freezes all
    input wire logic poweron_below_i, // Supply under power-on level
    input wire logic [3:0] brownout_below_i, // Under default, lvl1..3
    input wire logic volt_det_below_i, // Supply under detector level
    input wire logic internal_reset_disable_pin_i, // Reset-disable pin
    input wire logic external_reset_pin_n_i, // Reset pin, low
    input wire logic independent_watchdog_rst_i, // Watchdog reset
    input wire logic wakeup_pin_i, // Wakeup pin
    input wire logic regulator_bypass_i, // Regulator bypassed
    input wire logic [EXT_LINES-1:0] external_interrupt_line_i, // Lines
    input wire logic [3:0] rtc_event_i, // Alarm,wakeup,tamper,stamp
    input wire logic usb_wake_i, // USB wakeup
    input wire logic eth_wake_i, // Ethernet wakeup
    input wire logic periph_irq_i, // Peripheral irq or event
    input wire logic opt_load_i, // Option word valid
    input wire logic [2:0] opt_brownout_i, // Brownout option code
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [3:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte enables
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    output logic sys_reset_o, // Device reset, high
    output logic core_halt_o, // Core halted
    output logic core_clk_stop_o, // Core-domain clocks stopped
    output logic pll_osc_off_o, // PLL and oscillators off
    output logic regulator_off_o, // Regulator off, domain down
    output logic low_power_regulator_o, // Low-power regulator used
    output logic under_drive_o, // Regulator in under-drive
    output logic backup_battery_supply_en_o, // Battery backup usable
    output logic backup_sram_on_o, // Backup SRAM powered
    output logic volt_det_irq_o // Detector interrupt
);
    import pmrs_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (EXT_LINES < 1 || EXT_LINES > 32)
    begin : g_bad_lines
        $error("EXT_LINES must be 1 to 32");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int I_POR = 0;
    localparam int I_BRN = 1;
    localparam int I_DET = 5;
    localparam int I_DIS = 6;
    localparam int I_RSTN = 7;
    localparam int I_WDG = 8;
    localparam int I_WAKE = 9;
    localparam int I_BYP = 10;
    localparam int I_EXT = 11;
    localparam int I_RTC = I_EXT + EXT_LINES;
    localparam int I_USB = I_RTC + 4;
    localparam int I_ETH = I_USB + 1;
    localparam int SW = I_ETH + 1;
    // Supply reads low and reset pin high until real levels arrive
    localparam logic [SW-1:0] SYNC_RST = SW'(9'h081);

    logic [SW-1:0] s;

    pin_sync_bank #(
        .W(SW),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({eth_wake_i, usb_wake_i, rtc_event_i,
              external_interrupt_line_i, regulator_bypass_i, wakeup_pin_i,
              independent_watchdog_rst_i, external_reset_pin_n_i,
              internal_reset_disable_pin_i, volt_det_below_i,
              brownout_below_i, poweron_below_i}),
        .q_o(s)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    pmrs_s st;
    pmrs_s nxt;
    logic internal_en;
    logic brownout_trip;
    logic fault;
    logic ext_rst;
    logic det_act;
    logic det_evt;
    logic wake_rise;
    logic stop_wake;
    logic stby_wake;
    logic wb_hit;
    logic wr_ctrl;
    logic wr_stat;
    logic enter;

    always_comb
    begin
        nxt = st;
        internal_en = !(HAS_RESET_DISABLE_PIN && s[I_DIS]);
        // Brownout is ignored with internal reset off
        brownout_trip = internal_en && st.brownout_sel != `BRN_OFF
            && s[I_BRN + int'(st.brownout_sel[1:0])];
        fault = internal_en && (s[I_POR] || brownout_trip);
        // An outside supervisor reaches reset through the reset pin
        ext_rst = !s[I_RSTN] || s[I_WDG];
        det_act = st.ctrl[`CTRL_DET_EN] && internal_en;
        det_evt = det_act && ((st.ctrl[`CTRL_DET_FALL] && s[I_DET]
            && !st.det_prev) || (st.ctrl[`CTRL_DET_RISE] && !s[I_DET]
            && st.det_prev));
        wake_rise = s[I_WAKE] && !st.wake_prev;
        stop_wake = (|s[I_EXT +: EXT_LINES]) || (|s[I_RTC +: 4])
            || s[I_USB] || s[I_ETH] || det_evt;
        stby_wake = wake_rise || (|s[I_RTC +: 4]);
        wb_hit = wb_cyc_i && wb_stb_i && !st.wb_ack;
        wr_ctrl = wb_hit && wb_we_i && wb_adr_i == `REG_CTRL;
        wr_stat = wb_hit && wb_we_i && wb_adr_i == `REG_STATUS
            && wb_sel_i[0];
        enter = wr_ctrl && wb_sel_i[0] && wb_dat_i[`CTRL_ENTER];
        nxt.det_prev = s[I_DET];
        nxt.wake_prev = s[I_WAKE];

        // Options are taken once per power-up; off stays off
        if (opt_load_i && !st.opt_done)
        begin
            nxt.opt_done = 1'b1;
            if (opt_brownout_i != `BRN_KEEP && opt_brownout_i <= `BRN_OFF
                && st.brownout_sel != `BRN_OFF)
            begin
                nxt.brownout_sel = opt_brownout_i;
            end
        end

        // Register bus
        nxt.wb_ack = wb_hit;
        if (wr_ctrl && wb_sel_i[0])
        begin
            nxt.ctrl[7:0] = wb_dat_i[7:0];
        end
        if (wr_ctrl && wb_sel_i[1])
        begin
            nxt.ctrl[8] = wb_dat_i[8];
        end
        nxt.ctrl[`CTRL_ENTER] = 1'b0;
        // A new event beats a clear in the same cycle
        nxt.det_flag = (st.det_flag && !(wr_stat
            && wb_dat_i[`STAT_DET_FLAG])) || det_evt;
        nxt.stby_flag = st.stby_flag && !(wr_stat
            && wb_dat_i[`STAT_STBY_FLAG]);
        if (wb_hit)
        begin
            if (wb_adr_i == `REG_CTRL)
            begin
                nxt.wb_dat = {23'h0, st.ctrl};
            end
            else if (wb_adr_i == `REG_STATUS)
            begin
                nxt.wb_dat = {19'h0, st.state, 1'b0, st.brownout_sel,
                    !internal_en, st.stby_flag, st.det_flag, s[I_DET]};
            end
            else
            begin
                nxt.wb_dat = 32'h0;
            end
        end

        // Power state machine, reset sources first
        if (fault || ext_rst)
        begin
            nxt.state = ST_RESET;
            nxt.hold_cnt = `HOLD_CNT_W'(`RST_HOLD_CYC);
            if (st.state == ST_STANDBY)
            begin
                nxt.stby_flag = 1'b1;
            end
        end
        else
        begin
            case (st.state)
                ST_RESET:
                begin
                    if (st.hold_cnt != `HOLD_CNT_W'(0))
                    begin
                        nxt.hold_cnt = st.hold_cnt - `HOLD_CNT_W'(1);
                    end
                    else
                    begin
                        nxt.state = ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (enter && !wb_dat_i[`CTRL_DEEP])
                    begin
                        nxt.state = ST_SLEEP;
                    end
                    else if (enter && wb_dat_i[`CTRL_STANDBY]
                        && !s[I_BYP])
                    begin
                        nxt.state = ST_STANDBY;
                    end
                    else if (enter)
                    begin
                        // Bypassed regulator falls back to stop
                        nxt.state = ST_STOP;
                    end
                end
                ST_SLEEP:
                begin
                    if (periph_irq_i || stop_wake)
                    begin
                        nxt.state = ST_RUN;
                    end
                end
                ST_STOP:
                begin
                    if (stop_wake)
                    begin
                        nxt.state = ST_RUN;
                    end
                end
                ST_STANDBY:
                begin
                    if (stby_wake)
                    begin
                        nxt.state = ST_RESET;
                        nxt.hold_cnt = `HOLD_CNT_W'(`RST_HOLD_CYC);
                        nxt.stby_flag = 1'b1;
                    end
                end
                default:
                begin
                    nxt.state = ST_RESET;
                end
            endcase
        end

        // Core-domain registers are lost across reset and standby
        if (nxt.state == ST_RESET)
        begin
            nxt.ctrl = `CTRL_RESET;
        end

        // Outputs follow the next state so they change with it
        nxt.sys_reset = nxt.state == ST_RESET;
        nxt.core_halt = nxt.state inside {ST_SLEEP, ST_STOP, ST_STANDBY};
        nxt.clk_stop = nxt.state inside {ST_STOP, ST_STANDBY};
        nxt.osc_off = nxt.state inside {ST_STOP, ST_STANDBY};
        nxt.reg_off = nxt.state == ST_STANDBY;
        nxt.reg_lp = nxt.state == ST_STOP
            && nxt.ctrl[`CTRL_LP_REG];
        nxt.reg_ud = nxt.state == ST_STOP
            && nxt.ctrl[`CTRL_UNDER_DRIVE];
        nxt.bkp_batt = internal_en;
        nxt.bkp_sram = nxt.state != ST_STANDBY
            || nxt.ctrl[`CTRL_BKP_SRAM];
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.state <= ST_RESET;
            st.hold_cnt <= `HOLD_CNT_W'(`RST_HOLD_CYC);
            st.brownout_sel <= `BRN_DEFAULT_SEL;
            st.sys_reset <= 1'b1;
            st.bkp_sram <= 1'b1;
        end
        else if (ce_i)
        begin
            st <= nxt;
        end
    end

    assign wb_dat_o = st.wb_dat;
    assign wb_ack_o = st.wb_ack;
    assign sys_reset_o = st.sys_reset;
    assign core_halt_o = st.core_halt;
    assign core_clk_stop_o = st.clk_stop;
    assign pll_osc_off_o = st.osc_off;
    assign regulator_off_o = st.reg_off;
    assign low_power_regulator_o = st.reg_lp;
    assign under_drive_o = st.reg_ud;
    assign backup_battery_supply_en_o = st.bkp_batt;
    assign backup_sram_on_o = st.bkp_sram;
    assign volt_det_irq_o = st.det_flag;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    supply_reset_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && fault |=> sys_reset_o && st.state == ST_RESET)
        else $error("supply fault did not hold reset");

    brownout_lock_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && st.brownout_sel == `BRN_OFF |=> st.brownout_sel == `BRN_OFF)
        else $error("disabled brownout was re-enabled");

    det_irq_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && det_act && st.ctrl[`CTRL_DET_FALL] && s[I_DET]
        && !st.det_prev |=> volt_det_irq_o)
        else $error("falling supply did not flag interrupt");

    reset_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && !internal_en && !ext_rst && st.state == ST_RUN
        |=> !sys_reset_o)
        else $error("internal reset acted while disabled");

    det_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && !internal_en && !volt_det_irq_o && !wr_stat
        |=> !volt_det_irq_o && !backup_battery_supply_en_o)
        else $error("detector or battery active with reset off");

    sleep_halt_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st.state == ST_SLEEP |-> core_halt_o && !core_clk_stop_o
        && !pll_osc_off_o)
        else $error("sleep did more than halt the core");

    stop_clk_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st.state == ST_STOP |-> core_clk_stop_o && pll_osc_off_o
        && !regulator_off_o)
        else $error("stop outputs wrong");

    stop_reg_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st.state == ST_STOP |-> low_power_regulator_o
        == st.ctrl[`CTRL_LP_REG] && under_drive_o
        == st.ctrl[`CTRL_UNDER_DRIVE])
        else $error("stop regulator setting wrong");

    stop_wake_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && st.state == ST_STOP && !fault && !ext_rst
        && (|s[I_EXT +: EXT_LINES]) |=> st.state == ST_RUN && !core_halt_o)
        else $error("external line did not wake stop");

    standby_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st.state == ST_STANDBY |-> regulator_off_o && pll_osc_off_o)
        else $error("standby left regulator on");

    standby_wake_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && st.state == ST_STANDBY && wake_rise |=> sys_reset_o
        && st.stby_flag)
        else $error("wakeup rise did not leave standby");

    no_standby_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && st.state == ST_RUN && s[I_BYP] |=> st.state != ST_STANDBY)
        else $error("standby entered with bypassed regulator");

    restart_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && st.state == ST_RESET && st.hold_cnt != `HOLD_CNT_W'(0)
        |=> sys_reset_o && st.ctrl == `CTRL_RESET)
        else $error("reset sequence cut short");
endmodule

// ===== pmrs_far_side.sv
// Far-side model: outside supply supervisor, reset pin and wakeup pin
`timescale 1ns/1ps
module pmrs_far_side (
    input wire logic sys_clk_i, // System clock
    input wire logic supply_low_i, // Supply under 1.7 V
    input wire logic int_rst_off_i, // Internal reset to be disabled
    input wire logic wake_i, // Press the wakeup pin
    input wire logic rst_req_i, // Press the reset pin
    output logic internal_reset_disable_pin_o = 1'b0, // Reset-disable pin
    output logic external_reset_pin_n_o = 1'b1, // Reset pin, low
    output logic wakeup_pin_o = 1'b0 // Wakeup pin
);
    // ------------------------------------------------------------------
    // Supervisor
    // ------------------------------------------------------------------
    // Outside supervisor owns reset only when internal reset is off
    always @(posedge sys_clk_i)
    begin
        internal_reset_disable_pin_o <= int_rst_off_i;
        external_reset_pin_n_o <= !(rst_req_i
            || (int_rst_off_i && supply_low_i));
        wakeup_pin_o <= wake_i;
    end
endmodule

// ===== power_mode_reset_supervisor_test.sv
// Self-checking bench for the power mode and reset supervisor
`timescale 1ns/1ps
`include "pmrs_map.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module power_mode_reset_supervisor_test;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, poweron_below_i = 1'b0;
    logic volt_det_below_i = 1'b0, watchdog_rst = 1'b0;
    logic regulator_bypass_i = 1'b0;
    logic usb_wake_i = 1'b0, eth_wake_i = 1'b0, periph_irq_i = 1'b0;
    logic opt_load_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] brownout_below_i = '0, rtc_event_i = '0, wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [15:0] ext_lines = '0;
    logic [2:0] opt_brownout_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd, lfsr_q = 32'h305c;
    logic wb_ack_o, sys_reset_o, core_halt_o, core_clk_stop_o, pll_osc_off_o;
    logic regulator_off_o, low_power_regulator_o, under_drive_o, volt_det_irq_o;
    logic battery_en, sram_on, reset_disable_pin, reset_pin_n, wakeup_pin;
    logic supply_low = 1'b0, int_rst_off = 1'b0, wake = 1'b0, rst_req = 1'b0;
    int bad_count = 0, n_compared = 0;
    localparam logic [31:0] go_stop = 32'h1 << `CTRL_ENTER | 32'h1 << `CTRL_DEEP;
    localparam logic [31:0] go_stby = go_stop | 32'h1 << `CTRL_STANDBY;

    power_mode_reset_supervisor power_mode_reset_supervisor_i (
        .sys_clk_i, .rst_i, .ce_i, .poweron_below_i, .brownout_below_i,
        .volt_det_below_i, .internal_reset_disable_pin_i(reset_disable_pin),
        .external_reset_pin_n_i(reset_pin_n), .wakeup_pin_i(wakeup_pin),
        .independent_watchdog_rst_i(watchdog_rst), .regulator_bypass_i,
        .external_interrupt_line_i(ext_lines), .rtc_event_i, .usb_wake_i,
        .eth_wake_i, .periph_irq_i, .opt_load_i, .opt_brownout_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .sys_reset_o, .core_halt_o, .core_clk_stop_o,
        .pll_osc_off_o, .regulator_off_o, .low_power_regulator_o,
        .under_drive_o, .backup_battery_supply_en_o(battery_en),
        .backup_sram_on_o(sram_on), .volt_det_irq_o);
    pmrs_far_side pmrs_far_side_i (.sys_clk_i, .supply_low_i(supply_low),
        .int_rst_off_i(int_rst_off), .wake_i(wake), .rst_req_i(rst_req),
        .internal_reset_disable_pin_o(reset_disable_pin),
        .external_reset_pin_n_o(reset_pin_n), .wakeup_pin_o(wakeup_pin));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [3:0] brn_mask(input logic [2:0] code);
        return (code inside {3'h1, 3'h2, 3'h3}) ? 4'h1 << code : 4'h1;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic look(input int n);
        tick(n);
        @(negedge sys_clk_i);
    endtask
    // Request holds until the rising edge that samples ack high
    task automatic wb(input logic we, input logic [3:0] adr,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'h3;
        @(posedge sys_clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 20) bad_count++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (sys_reset_o !== 1'b0 && n < 300)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        `CHK(sys_reset_o, 1'b0)
    endtask
    task automatic boot(input logic [2:0] code);
        tick(1);
        rst_i <= 1'b1;
        tick(3);
        rst_i <= 1'b0;
        opt_load_i <= 1'b1;
        opt_brownout_i <= code;
        tick(1);
        opt_load_i <= 1'b0;
        wait_run();
    endtask
    task automatic quiet();
        tick(2);
        {ext_lines, rtc_event_i, usb_wake_i, eth_wake_i} <= '0;
        {wake, watchdog_rst, rst_req, periph_irq_i} <= '0;
    endtask
    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    initial
    begin
        #100000;
        bad_count++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        for (int c = 0; c < 5; c++)
        begin
            boot(3'(c));
            wb(1'b0, `REG_STATUS, '0);
            `CHK(rd[6:4], 3'(c))
            tick(1);
            brownout_below_i <= brn_mask(3'(c));
            look(6);
            `CHK(sys_reset_o, logic'(c != 4))
            tick(1);
            brownout_below_i <= '0;
            look(10);
            `CHK(sys_reset_o, logic'(c != 4))
            wait_run();
        end
        lfsr_q = lfsr(lfsr_q);
        wb(1'b1, 4'h8, lfsr_q);
        wb(1'b0, 4'h8, '0);
        `CHK(rd, 32'h0)
        for (int m = 1; m < 4; m++)
        begin
            wb(1'b1, `REG_CTRL, 32'h1 | 32'(m) << `CTRL_DET_FALL);
            for (int lv = 1; lv >= 0; lv--)
            begin
                tick(1);
                volt_det_below_i <= logic'(lv);
                look(6);
                `CHK(volt_det_irq_o, logic'(lv ? m[0] : m[1]))
                wb(1'b1, `REG_STATUS, 32'h1 << `STAT_DET_FLAG);
            end
        end
        wb(1'b1, `REG_CTRL, 32'h1 << `CTRL_ENTER);
        look(0);
        `CHK({core_halt_o, core_clk_stop_o, pll_osc_off_o}, 3'b100)
        tick(1);
        periph_irq_i <= 1'b1;
        quiet();
        look(3);
        `CHK(core_halt_o, 1'b0)
        for (int r = 0; r < 5; r++)
        begin
            tick(1);
            regulator_bypass_i <= logic'(r == 4);
            tick(3);
            wb(1'b1, `REG_CTRL, (r == 4 ? go_stby : go_stop) | 32'(r % 4) << 3);
            look(0);
            `CHK({core_clk_stop_o, pll_osc_off_o, regulator_off_o}, 3'b110)
            `CHK(low_power_regulator_o, logic'(r == 1 || r == 3))
            `CHK(under_drive_o, logic'(r >= 2 && r < 4))
            lfsr_q = lfsr(lfsr_q);
            tick(1);
            case (r)
                0: ext_lines <= lfsr_q[15:0] | 16'h1;
                1: rtc_event_i <= 4'h1 << lfsr_q[1:0];
                2: usb_wake_i <= 1'b1;
                default: eth_wake_i <= 1'b1;
            endcase
            quiet();
            look(4);
            `CHK(core_halt_o, 1'b0)
        end
        tick(1);
        regulator_bypass_i <= 1'b0;
        tick(3);
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, `REG_CTRL, go_stby | 32'(k % 2) << `CTRL_BKP_SRAM);
            look(0);
            `CHK({regulator_off_o, pll_osc_off_o, core_halt_o}, 3'b111)
            `CHK(sram_on, logic'(k % 2))
            tick(1);
            case (k)
                0: wake <= 1'b1;
                1: rtc_event_i <= 4'h1 << lfsr_q[3:2];
                2: watchdog_rst <= 1'b1;
                default: rst_req <= 1'b1;
            endcase
            quiet();
            look(4);
            `CHK(sys_reset_o, 1'b1)
            wait_run();
            wb(1'b0, `REG_STATUS, '0);
            `CHK({rd[12:8], rd[`STAT_STBY_FLAG]}, 6'h05)
            wb(1'b1, `REG_STATUS, 32'h1 << `STAT_STBY_FLAG);
            wb(1'b0, `REG_CTRL, '0);
            `CHK(rd[8:0], 9'h000)
        end
        int_rst_off <= 1'b1;
        boot(`BRN_OFF);
        `CHK(battery_en, 1'b0)
        wb(1'b1, `REG_CTRL, 32'h3);
        tick(1);
        poweron_below_i <= 1'b1;
        volt_det_below_i <= 1'b1;
        look(6);
        `CHK({sys_reset_o, volt_det_irq_o}, 2'b00)
        tick(1);
        supply_low <= 1'b1;
        look(6);
        `CHK(sys_reset_o, 1'b1)
        tick(1);
        supply_low <= 1'b0;
        ce_i <= 1'b0;
        look(30);
        `CHK(sys_reset_o, 1'b1)
        tick(1);
        ce_i <= 1'b1;
        wait_run();
        complete_run();
    end
endmodule
